// ### pwmc_map.svh
// register offsets, field positions and reset values of the modulator
`ifndef PWMC_MAP_SVH
`define PWMC_MAP_SVH

// word indexes on the bus, byte address is four times the index
`define PWMC_IDX_CFG      6'h00
`define PWMC_IDX_SELPOL   6'h01
`define PWMC_IDX_ENABLE   6'h02
`define PWMC_IDX_PRESC    6'h03
`define PWMC_IDX_SCALE0   6'h04
`define PWMC_IDX_SCALE1   6'h05
`define PWMC_IDX_CTRL     6'h06
`define PWMC_IDX_PORT     6'h07
`define PWMC_IDX_DDR      6'h08
`define PWMC_IDX_CNT      6'h09
`define PWMC_IDX_PER      6'h0D
`define PWMC_IDX_DTY      6'h11
`define PWMC_IDX_LAST     6'h14

// fields of the join and prescale register
`define PWMC_JOIN23_BIT   7
`define PWMC_JOIN01_BIT   6
`define PWMC_CODEB_MSB    5
`define PWMC_CODEB_LSB    3
`define PWMC_CODEA_MSB    2
`define PWMC_CODEA_LSB    0
// fields of the clock select and polarity register
`define PWMC_SEL_MSB      7
`define PWMC_SEL_LSB      4
`define PWMC_POL_MSB      3
`define PWMC_POL_LSB      0
// control register
`define PWMC_CENTER_BIT   0

// reset values
`define PWMC_RST_BYTE     8'h00
`define PWMC_RST_NIB      4'h0
`define PWMC_RST_PRESC    7'h00

`endif

// ### pwmc_pkg.sv
// shared types of the modulator
package pwmc_pkg;

    // counting direction in center-aligned operation
    typedef enum logic {DIR_UP, DIR_DOWN} pwmc_dir_type;

    // one channel byte
    typedef logic [7:0] pwmc_byte_type;

endpackage

// ### pwmc_top.sv
// four-channel pulse-width modulator with apb registers and shared port pins
//
// Functional notes
// - four 8-bit channels, or pairs joined into 16-bit channels
// - period and duty written while enabled wait until rollover or disable
// - writes while disabled reach the buffer, then the active latch one cycle later
// - counter write clears the counter and latches buffered period and duty
// - enabled channel overrides its port pin; unused pins stay general I/O
// - joined pair 2/3: ch2 high byte, output on pin 2, ch3 clock
// - joined pair 0/1: ch0 high byte, output on pin 0, ch1 clock
// - clock A and B are bus clock divided by two to the 3-bit code
// - select bit picks unscaled clock at 0, scaled clock at 1
// - changing clock select while running may cut or stretch one pulse
// - polarity 0 starts low, high at duty; polarity 1 the reverse
// - duty counts low time at polarity 0 left-aligned, high time at 1
// - enable forces pin output without touching its direction bit
// - enable gates channel clock; all disabled stops prescale counter
// - channel clock starts and stops only on a clock edge
// - output appears when the selected clock begins its next cycle
// - 7-bit free prescale counter, writable only in special mode
// - scaled clock is base clock divided by scale plus one, then two
// - left-aligned period match resets; center-aligned match reverses
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "pwmc_map.svh"

module pwmc_top
(
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SPECIAL_MODE,
    input  wire logic [3:0]  PIN_IN,
    output logic      [3:0]  PIN_OUT,
    output logic      [3:0]  PIN_OE_N
);

    // ==========================================================
    // state
    logic                 pready_q;
    logic                 pslverr_q;
    logic [31:0]          prdata_q;
    logic [7:0]           cfg_q;
    logic [7:0]           selpol_q;
    logic [3:0]           en_q;
    logic [6:0]           presc_q;
    logic [7:0]           scale_q   [2];
    logic [7:0]           scnt_q    [2];
    logic [1:0]           half_q;
    logic                 center_q;
    logic [3:0]           port_q;
    logic [3:0]           ddr_q;
    logic [3:0]           pin_s1_q;
    logic [3:0]           pin_s2_q;
    logic                 spec_s1_q;
    logic                 spec_s2_q;
    pwmc_pkg::pwmc_byte_type cnt_q   [4];
    pwmc_pkg::pwmc_byte_type per_buf_q [4];
    pwmc_pkg::pwmc_byte_type per_lat_q [4];
    pwmc_pkg::pwmc_byte_type dty_buf_q [4];
    pwmc_pkg::pwmc_byte_type dty_lat_q [4];
    pwmc_pkg::pwmc_dir_type  dir_q   [4];
    logic [3:0]           run_q;
    logic [3:0]           wave_q;
    logic [3:0]           pin_out_q;
    logic [3:0]           pin_oe_n_q;

    // ==========================================================
    // helper functions
    // divided clock tick: low code bits of the prescaler all ones
    function automatic logic pre_tick(input logic [2:0] code,
                                      input logic [6:0] cnt);
        logic [6:0] m;
        m = ~(7'h7F << code);
        return (cnt & m) == m;
    endfunction

    // channel number of a word index inside a block of four
    function automatic logic [1:0] chan_of(input logic [5:0] idx,
                                           input logic [5:0] base);
        logic [5:0] d;
        d = idx - base;
        return d[1:0];
    endfunction

    // word index lies inside a block of four
    function automatic logic in_block(input logic [5:0] idx,
                                      input logic [5:0] base);
        return (idx >= base) && (idx < base + 6'h04);
    endfunction

    // ==========================================================
    // bus decode
    wire [5:0] widx     = PADDR[7:2];
    wire       access   = PSEL & PENABLE;
    wire       fire     = access & pready_q;
    wire       wr_fire  = fire & PWRITE;
    wire       mapped   = widx <= `PWMC_IDX_LAST;
    wire [7:0] wbyte    = PWDATA[7:0];
    wire       is_cnt   = in_block(widx, `PWMC_IDX_CNT);
    wire       is_per   = in_block(widx, `PWMC_IDX_PER);
    wire       is_dty   = in_block(widx, `PWMC_IDX_DTY);
    wire [1:0] cnt_ch   = chan_of(widx, `PWMC_IDX_CNT);
    wire [1:0] per_ch   = chan_of(widx, `PWMC_IDX_PER);
    wire [1:0] dty_ch   = chan_of(widx, `PWMC_IDX_DTY);
    wire       presc_wr = wr_fire & (widx == `PWMC_IDX_PRESC);
    wire       spec     = spec_s2_q;
    wire       any_en   = |en_q;
    wire [1:0] join_w   = {cfg_q[`PWMC_JOIN23_BIT],
                           cfg_q[`PWMC_JOIN01_BIT]};
    wire [3:0] sel_w    = selpol_q[`PWMC_SEL_MSB:`PWMC_SEL_LSB];
    wire [3:0] pol_w    = selpol_q[`PWMC_POL_MSB:`PWMC_POL_LSB];
    wire [2:0] code_w [2];
    assign code_w[0] = cfg_q[`PWMC_CODEA_MSB:`PWMC_CODEA_LSB];
    assign code_w[1] = cfg_q[`PWMC_CODEB_MSB:`PWMC_CODEB_LSB];

    // read multiplexer, bits above the byte read zero
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = `PWMC_RST_BYTE;
        if (is_cnt)
            rd_byte = cnt_q[cnt_ch];
        else if (is_per)
            rd_byte = per_buf_q[per_ch];
        else if (is_dty)
            rd_byte = dty_buf_q[dty_ch];
        else
            case (widx)
                `PWMC_IDX_CFG:    rd_byte = cfg_q;
                `PWMC_IDX_SELPOL: rd_byte = selpol_q;
                `PWMC_IDX_ENABLE: rd_byte = {4'h0, en_q};
                `PWMC_IDX_PRESC:  rd_byte = {1'b0, presc_q};
                `PWMC_IDX_SCALE0: rd_byte = scale_q[0];
                `PWMC_IDX_SCALE1: rd_byte = scale_q[1];
                `PWMC_IDX_CTRL:   rd_byte = {7'h00, center_q};
                `PWMC_IDX_PORT:   rd_byte = {4'h0,
                                     (ddr_q & port_q) | (~ddr_q & pin_s2_q)};
                `PWMC_IDX_DDR:    rd_byte = {4'h0, ddr_q};
                default:          rd_byte = `PWMC_RST_BYTE;
            endcase
    end

    // ==========================================================
    // apb slave: one wait state, answer on the second access cycle
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            prdata_q  <= (access & ~pready_q) ? {24'h000000, rd_byte}
                                              : 32'h0000_0000;
        end
    end

    // control registers
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cfg_q    <= `PWMC_RST_BYTE;
            selpol_q <= `PWMC_RST_BYTE;
            en_q     <= `PWMC_RST_NIB;
            center_q <= 1'b0;
            port_q   <= `PWMC_RST_NIB;
            ddr_q    <= `PWMC_RST_NIB;
        end
        else if (wr_fire)
            case (widx)
                `PWMC_IDX_CFG:    cfg_q    <= wbyte;
                `PWMC_IDX_SELPOL: selpol_q <= wbyte;
                `PWMC_IDX_ENABLE: en_q     <= wbyte[3:0];
                `PWMC_IDX_CTRL:   center_q <= wbyte[`PWMC_CENTER_BIT];
                `PWMC_IDX_PORT:   port_q   <= wbyte[3:0];
                `PWMC_IDX_DDR:    ddr_q    <= wbyte[3:0];
                default:          cfg_q    <= cfg_q;
            endcase
    end

    // pin and mode synchronisers
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pin_s1_q  <= `PWMC_RST_NIB;
            pin_s2_q  <= `PWMC_RST_NIB;
            spec_s1_q <= 1'b0;
            spec_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q  <= PIN_IN;
            pin_s2_q  <= pin_s1_q;
            spec_s1_q <= SPECIAL_MODE;
            spec_s2_q <= spec_s1_q;
        end
    end

    // ==========================================================
    // prescaler: runs only while a channel is enabled
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            presc_q <= `PWMC_RST_PRESC;
        else if (presc_wr && spec)
            presc_q <= wbyte[6:0];
        else if (any_en)
            presc_q <= presc_q + 7'h01;
    end

    // clock A / B ticks and scaled clocks S0 / S1
    logic [1:0] tick_ab;
    logic [1:0] s_tick;
    logic [1:0] scale_wr;
    for (genvar k = 0; k < 2; k++)
    begin : g_clk
        assign tick_ab[k]  = any_en & pre_tick(code_w[k], presc_q);
        assign s_tick[k]   = tick_ab[k] & (scnt_q[k] == 8'h00)
                             & half_q[k];
        assign scale_wr[k] = wr_fire &
                             (widx == `PWMC_IDX_SCALE0 + 6'(k));
    end

    // scale down-counters, half toggles per reload to divide by two
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int k = 0; k < 2; k++)
            begin
                scale_q[k] <= `PWMC_RST_BYTE;
                scnt_q[k]  <= `PWMC_RST_BYTE;
            end
            half_q <= 2'h0;
        end
        else
            for (int k = 0; k < 2; k++)
            begin
                if (scale_wr[k])
                begin
                    scale_q[k] <= wbyte;
                    scnt_q[k]  <= wbyte;
                end
                else if (tick_ab[k])
                begin
                    scnt_q[k] <= (scnt_q[k] == 8'h00) ? scale_q[k]
                                                      : scnt_q[k] - 8'h01;
                    if (scnt_q[k] == 8'h00)
                        half_q[k] <= ~half_q[k];
                end
            end
    end

    // per-channel clock selection
    logic [3:0] ch_tick;
    for (genvar i = 0; i < 4; i++)
    begin : g_sel
        assign ch_tick[i] = sel_w[i] ? s_tick[i/2] : tick_ab[i/2];
    end

    // ==========================================================
    // channels: a joined pair is driven by its even (high byte) channel
    logic [15:0] nxt    [4];
    logic [3:0]  raw_tk;
    logic [3:0]  tk;
    logic [3:0]  roll;
    logic [3:0]  flip;
    logic [3:0]  lvl;
    logic [3:0]  slave;
    logic [3:0]  upd;
    logic [3:0]  cnt_wr;
    pwmc_pkg::pwmc_byte_type cnt_d [4];

    for (genvar c = 0; c < 4; c++)
    begin : g_ch
        localparam int L = (c % 2 == 0) ? c + 1 : c;
        localparam int H = (c % 2 == 1) ? c - 1 : c;
        wire        joined = (c % 2 == 0) & join_w[c/2];
        wire [15:0] cw = joined ? {cnt_q[c], cnt_q[L]}
                                : {8'h00, cnt_q[c]};
        wire [15:0] pw = joined ? {per_lat_q[c], per_lat_q[L]}
                                : {8'h00, per_lat_q[c]};
        wire [15:0] dw = joined ? {dty_lat_q[c], dty_lat_q[L]}
                                : {8'h00, dty_lat_q[c]};
        wire        at_per  = cw >= pw;
        wire        at_zero = cw == 16'h0000;
        wire        up      = dir_q[c] == pwmc_pkg::DIR_UP;
        wire [15:0] inc     = cw + 16'h0001;
        wire [15:0] dec     = cw - 16'h0001;
        wire        own     = slave[c] ? en_q[H] : en_q[c];

        assign slave[c]  = (c % 2 == 1) & join_w[c/2];
        assign cnt_wr[c] = wr_fire & is_cnt & (cnt_ch == 2'(c));
        assign raw_tk[c] = joined ? ch_tick[L] : ch_tick[c];
        assign tk[c]     = run_q[c] & raw_tk[c] & ~slave[c];
        // left-aligned wraps at period, center-aligned turns round
        assign nxt[c] = !center_q ? (at_per ? 16'h0000 : inc)
                      : up ? (at_per ? dec : inc)
                           : (at_zero ? inc : dec);
        assign roll[c] = tk[c] & (center_q ? (~up & at_zero) : at_per);
        assign flip[c] = tk[c] & center_q & (up ? at_per : at_zero);
        // duty match flips the level away from the start state
        assign lvl[c] = pol_w[c] ^
                        ((nxt[c] >= dw) & (dw < pw));
        // active latches follow buffers while off, on rollover or reset
        // a partner byte's counter write latches only inside a joined pair
        assign upd[c] = ~own | (slave[c] ? roll[H] : roll[c])
                      | cnt_wr[c]
                      | (join_w[c/2] & (cnt_wr[L] | cnt_wr[H]));
        assign cnt_d[c] = cnt_wr[c] ? 8'h00
                        : slave[c] ? (tk[H] ? nxt[H][7:0] : cnt_q[c])
                        : joined ? (tk[c] ? nxt[c][15:8] : cnt_q[c])
                        : (tk[c] ? nxt[c][7:0] : cnt_q[c]);
    end

    // counters, direction, run gate and waveform level
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            for (int i = 0; i < 4; i++)
            begin
                cnt_q[i] <= `PWMC_RST_BYTE;
                dir_q[i] <= pwmc_pkg::DIR_UP;
            end
            run_q  <= `PWMC_RST_NIB;
            wave_q <= `PWMC_RST_NIB;
        end
        else
            for (int i = 0; i < 4; i++)
            begin
                cnt_q[i] <= cnt_d[i];
                if (!center_q || cnt_wr[i])
                    dir_q[i] <= pwmc_pkg::DIR_UP;
                else if (flip[i])
                    dir_q[i] <= (dir_q[i] == pwmc_pkg::DIR_UP)
                                ? pwmc_pkg::DIR_DOWN : pwmc_pkg::DIR_UP;
                if (raw_tk[i])
                    run_q[i] <= en_q[i];
                if (!run_q[i])
                    wave_q[i] <= pol_w[i];
                else if (tk[i])
                    wave_q[i] <= lvl[i];
            end
    end

    // period and duty buffers and active latches
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            for (int i = 0; i < 4; i++)
            begin
                per_buf_q[i] <= `PWMC_RST_BYTE;
                per_lat_q[i] <= `PWMC_RST_BYTE;
                dty_buf_q[i] <= `PWMC_RST_BYTE;
                dty_lat_q[i] <= `PWMC_RST_BYTE;
            end
        else
            for (int i = 0; i < 4; i++)
            begin
                if (wr_fire && is_per && per_ch == 2'(i))
                    per_buf_q[i] <= wbyte;
                if (wr_fire && is_dty && dty_ch == 2'(i))
                    dty_buf_q[i] <= wbyte;
                if (upd[i])
                begin
                    per_lat_q[i] <= per_buf_q[i];
                    dty_lat_q[i] <= dty_buf_q[i];
                end
            end
    end

    // ==========================================================
    // shared port pins: enabled channel owns the pin
    wire [3:0] pwm_own = en_q & ~slave;
    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pin_out_q  <= `PWMC_RST_NIB;
            pin_oe_n_q <= 4'hF;
        end
        else
        begin
            pin_out_q  <= (pwm_own & wave_q) | (~pwm_own & port_q);
            pin_oe_n_q <= ~(pwm_own | ddr_q);
        end
    end

    assign PRDATA   = prdata_q;
    assign PREADY   = pready_q;
    assign PSLVERR  = pslverr_q;
    assign PIN_OUT  = pin_out_q;
    assign PIN_OE_N = pin_oe_n_q;

    // ==========================================================
    // assertions
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    sequence s_cnt_write0;
        cnt_wr[0] && !join_w[0];
    endsequence

    sequence s_enabled_two3;
        en_q[3] && !join_w[1] ##1 en_q[3] && !join_w[1];
    endsequence

    AST_PRESC_STOP: assert property (
        !any_en && !presc_wr |=> $stable(presc_q))
        else $error("prescaler moved with all channels off");

    AST_PRESC_RUN: assert property (
        any_en && !presc_wr |=> presc_q == 7'($past(presc_q) + 7'h01))
        else $error("prescaler did not count");

    AST_PRESC_NORMAL_WR: assert property (
        presc_wr && !spec && !any_en |=> $stable(presc_q))
        else $error("prescaler written in normal mode");

    AST_CNT_CLEAR: assert property (
        s_cnt_write0 |=> cnt_q[0] == 8'h00
                         && per_lat_q[0] == $past(per_buf_q[0]))
        else $error("counter write did not clear and latch");

    AST_HOLD_ON: assert property (
        en_q[0] && !join_w[0] && !roll[0] && !cnt_wr[0]
        |=> $stable(dty_lat_q[0]))
        else $error("duty latch changed mid period");

    AST_DIRECT_OFF: assert property (
        !en_q[2] && !join_w[1] ##1 !en_q[2]
        |-> per_lat_q[2] == $past(per_buf_q[2]))
        else $error("latch not following buffer while off");

    AST_OE_FORCED: assert property (
        en_q[2] && !join_w[1] && !(wr_fire && widx == `PWMC_IDX_DDR)
        |=> !PIN_OE_N[2] && $stable(ddr_q[2]))
        else $error("enabled channel pin not driven");

    AST_PIN_OVERRIDE: assert property (
        s_enabled_two3 |-> PIN_OUT[3] == $past(wave_q[3]))
        else $error("port data overrode modulator output");

    AST_IDLE_LEVEL: assert property (
        !run_q[1] |=> wave_q[1] == $past(pol_w[1]))
        else $error("idle channel not at start level");

    AST_CLK_SYNC: assert property (
        $changed(run_q[0]) |-> $past(raw_tk[0]))
        else $error("channel clock gated off an edge");

    AST_SCALE: assert property (
        s_tick[1] |-> tick_ab[1] && scnt_q[1] == 8'h00)
        else $error("scaled clock off its base tick");

endmodule

// ### pwmc_tb_top.sv
// self-checking testbench of the four-channel modulator
`timescale 1ns/1ps
`include "pwmc_map.svh"

module pwmc_tb_top;

    logic        CLOCK;
    logic        RSTN;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        SPECIAL_MODE;
    logic [3:0]  PIN_IN;
    logic [3:0]  PIN_OUT;
    logic [3:0]  PIN_OE_N;
    int          num_errors;
    int          num_checks;
    logic [31:0] rd_q;
    logic [31:0] rd2;
    logic        er;
    int          per;
    int          hi;

    // ==========================================================
    // device under test
    pwmc_top i_dut
    (
        .CLOCK        (CLOCK),
        .RSTN         (RSTN),
        .PSEL         (PSEL),
        .PENABLE      (PENABLE),
        .PWRITE       (PWRITE),
        .PADDR        (PADDR),
        .PWDATA       (PWDATA),
        .PRDATA       (PRDATA),
        .PREADY       (PREADY),
        .PSLVERR      (PSLVERR),
        .SPECIAL_MODE (SPECIAL_MODE),
        .PIN_IN       (PIN_IN),
        .PIN_OUT      (PIN_OUT),
        .PIN_OE_N     (PIN_OE_N)
    );

    // 25 MHz bus clock
    always #20 CLOCK = ~CLOCK;

    // ==========================================================
    // compare, verdict and bus tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [5:0] idx,
                       input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= {idx, 2'b00};
        PWDATA  <= {24'h000000, wd};
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLOCK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 50);
        if (PREADY !== 1'b1)
            num_errors++;
        rd_q = PRDATA;
        er   = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check(rd_q, {24'h000000, e});
    endtask

    // period and high time of pin b between two rising edges
    task automatic meas(input int b);
        logic p;
        p = PIN_OUT[b];
        per = 0;
        hi = 0;
        repeat (3000)
        begin
            @(posedge CLOCK);
            #1;
            if (!p && PIN_OUT[b])
                break;
            p = PIN_OUT[b];
        end
        per = 1;
        hi = 1;
        p = 1'b1;
        while (per < 3000)
        begin
            @(posedge CLOCK);
            #1;
            if (!p && PIN_OUT[b])
                break;
            p = PIN_OUT[b];
            per++;
            hi += int'(p);
        end
    endtask

    // ==========================================================
    // watchdog against a hang
    initial
    begin
        #(40 * 40000);
        num_errors++;
        final_report();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        CLOCK = 0; RSTN = 0; PSEL = 0; PENABLE = 0; PWRITE = 0;
        PADDR = 8'h00; PWDATA = 32'h0; SPECIAL_MODE = 0; PIN_IN = 4'hA;
        num_errors = 0; num_checks = 0;
        repeat (8) @(posedge CLOCK);
        RSTN <= 1'b1;
        check(PIN_OE_N, 4'hF);
        for (int i = 0; i < 9; i++)
            rdchk(i[5:0], (i == 7) ? 8'h0A : 8'h00);
        apb(1'b0, 6'h15, 8'h00);
        check({rd_q[0], er}, 2'b01);
        wr(`PWMC_IDX_SELPOL, 8'hA5);
        rdchk(`PWMC_IDX_SELPOL, 8'hA5);
        // prescaler writes only in special mode, stopped while idle
        wr(`PWMC_IDX_PRESC, 8'h55);
        rdchk(`PWMC_IDX_PRESC, 8'h00);
        SPECIAL_MODE <= 1'b1;
        repeat (3) @(posedge CLOCK);
        wr(`PWMC_IDX_PRESC, 8'h55);
        repeat (5) @(posedge CLOCK);
        rdchk(`PWMC_IDX_PRESC, 8'h55);
        SPECIAL_MODE <= 1'b0;
        // general purpose pins
        wr(`PWMC_IDX_DDR, 8'h02);
        wr(`PWMC_IDX_PORT, 8'h02);
        repeat (2) @(posedge CLOCK);
        check({PIN_OUT[1], PIN_OE_N}, 5'h1D);
        rdchk(`PWMC_IDX_PORT, 8'h0A);
        // start level and pin takeover on enable
        wr(`PWMC_IDX_SELPOL, 8'h01);
        wr(`PWMC_IDX_CFG, 8'h07);
        wr(`PWMC_IDX_PER, 8'h09);
        wr(`PWMC_IDX_DTY, 8'h03);
        wr(`PWMC_IDX_ENABLE, 8'h01);
        repeat (2) @(posedge CLOCK);
        check({PIN_OE_N[0], PIN_OUT[0]}, 2'b01);
        rdchk(`PWMC_IDX_DDR, 8'h02);
        apb(1'b0, `PWMC_IDX_PRESC, 8'h00);
        rd2 = rd_q;
        apb(1'b0, `PWMC_IDX_PRESC, 8'h00);
        check((rd_q - rd2) & 32'h7F, 32'h04);
        wr(`PWMC_IDX_ENABLE, 8'h00);
        repeat (2) @(posedge CLOCK);
        check(PIN_OE_N[0], 1'b1);
        // clock A rate codes, low time at polarity 0
        wr(`PWMC_IDX_SELPOL, 8'h00);
        wr(`PWMC_IDX_ENABLE, 8'h01);
        for (int c = 0; c < 4; c++)
        begin
            wr(`PWMC_IDX_CFG, c[7:0]);
            meas(0);
            meas(0);
            check(per, 10 << c);
            check(hi, 7 << c);
        end
        wr(`PWMC_IDX_CFG, 8'h00);
        wr(`PWMC_IDX_PER, 8'h13);
        meas(0);
        meas(0);
        check(per, 20);
        wr(`PWMC_IDX_PER, 8'h09);
        wr(`PWMC_IDX_CNT, 8'h00);
        meas(0);
        check(per, 10);
        // scaled clock S0 with scale 1 divides clock A by four
        wr(`PWMC_IDX_SCALE0, 8'h01);
        wr(`PWMC_IDX_SELPOL, 8'h10);
        meas(0);
        meas(0);
        check(per, 40);
        // joined pair 0/1 as one 16-bit channel on pin 0
        wr(`PWMC_IDX_ENABLE, 8'h00);
        wr(`PWMC_IDX_SELPOL, 8'h00);
        wr(`PWMC_IDX_DDR, 8'h00);
        wr(`PWMC_IDX_CFG, 8'h40);
        wr(`PWMC_IDX_PER, 8'h00);
        wr(`PWMC_IDX_PER + 6'h01, 8'h09);
        wr(`PWMC_IDX_DTY, 8'h00);
        wr(`PWMC_IDX_DTY + 6'h01, 8'h03);
        wr(`PWMC_IDX_ENABLE, 8'h01);
        meas(0);
        meas(0);
        check({per[7:0], hi[7:0]}, 16'h0A07);
        check(PIN_OE_N[1], 1'b1);
        // channels 2 and 3 take their pins over the port data
        wr(`PWMC_IDX_PORT, 8'h0E);
        wr(`PWMC_IDX_ENABLE, 8'h0D);
        repeat (2) @(posedge CLOCK);
        check(PIN_OE_N, 4'h2);
        check(PIN_OUT[3:2], 2'b00);
        // center-aligned channel 0 turns round at period: 2 x 9 ticks
        wr(`PWMC_IDX_ENABLE, 8'h00);
        wr(`PWMC_IDX_CFG, 8'h00);
        wr(`PWMC_IDX_PER, 8'h09);
        wr(`PWMC_IDX_DTY, 8'h03);
        wr(`PWMC_IDX_CTRL, 8'h01);
        wr(`PWMC_IDX_ENABLE, 8'h01);
        meas(0);
        meas(0);
        check(per, 18);
        final_report();
    end

endmodule
